// *** hdl/multichannel_pulse_output.sv ***
// top of the multichannel pulse output block: bus slave, command decode, engines, outputs
//
// Summary of operation
// - at most eight outputs under engine control; a ninth request fails.
// - low and high phase lengths count one-millisecond ticks.
// - lengths 1..32767 fine, or even 2..32766 in coarse mode.
// - counted target 1..2147483647; a negative target runs until disabled.
// - every start clears the tick counter and begins with the low phase.
// - a counted run stops and frees its engine after the target pulse.
// - a status query tells whether a counted run reached its target.
// - status is true while running or forced, false once disabled or finished.
// - after disable the output follows the ordinary scan value.
// - force-high drives the output high at once and occupies an engine.
// - force-low drives the output low at once and occupies an engine.
// - each command reports success or failure for bad parameters, limit, missing output.
`timescale 1ns/1ps
`default_nettype none
module multichannel_pulse_output #(
   parameter int unsigned TICK_CYCLES = pulse_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic                                 sys_clk,
   input  wire logic                                 rstn,

   // ahb-lite slave
   input  wire logic                                 hsel,
   input  wire logic [31:0]                          haddr,
   input  wire logic [1:0]                           htrans,
   input  wire logic                                 hwrite,
   input  wire logic [2:0]                           hsize,
   input  wire logic [31:0]                          hwdata,
   input  wire logic                                 hready,
   output logic                                      hreadyout,
   output logic                                      hresp,
   output logic [31:0]                               hrdata,

   // output boards
   input  wire logic [pulse_pkg::NUM_SLOTS-1:0]      board_present,
   input  wire logic [pulse_pkg::NUM_OUTPUTS-1:0]    scan_out,
   output logic [pulse_pkg::NUM_OUTPUTS-1:0]         channel_out,

   // interrupt
   output logic                                      irq
);
   localparam int unsigned NE = pulse_pkg::NUM_ENGINES;

   // lowest set bit of an engine vector
   function automatic logic [2:0] first_set(input logic [NE-1:0] vec);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = NE - 1; i >= 0; i--) begin
         if (vec[i])
            idx = 3'(i);
      end
      return idx;
   endfunction

   // phase length check for either variant
   function automatic logic time_ok(input logic [15:0] t, input logic coarse);
      logic ok;
      ok = coarse ? (t >= pulse_pkg::COARSE_MIN && t <= pulse_pkg::COARSE_MAX && !t[0])
                  : (t >= pulse_pkg::FINE_MIN && t <= pulse_pkg::FINE_MAX);
      return ok;
   endfunction

   // bus data phase state
   logic        wr_pend;
   logic        rd_pend;
   logic [7:0]  addr_q;

   // software registers
   logic [15:0] low_time;
   logic [15:0] high_time;
   logic [31:0] pulse_num;
   logic        coarse;
   logic [1:0]  result;
   logic [1:0]  irq_status;
   logic [1:0]  irq_mask;

   // engine state
   logic [7:0]    target [NE];
   logic [NE-1:0] eng_busy;
   logic [NE-1:0] eng_level;
   logic [NE-1:0] eng_done;
   logic          tick;

   // zero wait states: a write lands as its data phase closes
   wire addr_phase = hsel && htrans[1] && hready;
   wire wr_en      = wr_pend;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         addr_q  <= 8'h00;
      end else if (hready) begin
         wr_pend <= addr_phase && hwrite;
         rd_pend <= addr_phase && !hwrite;
         addr_q  <= addr_phase ? haddr[7:0] : addr_q;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // command decode
   wire        cmd_go   = wr_en && (addr_q == pulse_pkg::OFF_CMD);
   wire [2:0]  cmd_op   = hwdata[pulse_pkg::CMD_OP_LSB +: 3];
   wire [2:0]  cmd_slot = hwdata[pulse_pkg::CMD_SLOT_LSB +: 3];
   wire [5:0]  cmd_ch   = hwdata[pulse_pkg::CMD_CH_LSB +: 6];
   // outputs count from one on the bus, from zero inside
   wire [4:0]  ch_low   = 5'(cmd_ch - 6'h01);
   wire [7:0]  out_idx  = {cmd_slot, ch_low};

   wire is_start  = (cmd_op == pulse_pkg::OP_CONTINUOUS) || (cmd_op == pulse_pkg::OP_COUNTED);
   wire is_force  = (cmd_op == pulse_pkg::OP_FORCE_HIGH) || (cmd_op == pulse_pkg::OP_FORCE_LOW);
   wire is_addr   = (cmd_op != pulse_pkg::OP_NONE) && (cmd_op != pulse_pkg::OP_RESET_ALL);
   wire need_eng  = is_start || is_force;

   // the output must exist on a fitted board
   wire ch_ok     = (cmd_ch >= 6'h01) && (cmd_ch <= 6'h20) && board_present[cmd_slot];

   wire params_ok = time_ok(low_time, coarse) && time_ok(high_time, coarse) &&
                    ((cmd_op != pulse_pkg::OP_COUNTED) || (pulse_num != 32'h0000_0000));

   // engine lookup: reuse the engine already on this output, else take a free one
   logic [NE-1:0] hit_vec;
   genvar e;
   generate
      for (e = 0; e < NE; e++) begin : g_hit
         assign hit_vec[e] = eng_busy[e] && (target[e] == out_idx);
      end
   endgenerate

   // a start on an owned output restarts its engine, no new slot
   wire        hit      = |hit_vec;
   wire [NE-1:0] free_vec = ~eng_busy;
   wire        avail    = hit || (|free_vec);
   wire [2:0]  sel      = hit ? first_set(hit_vec) : first_set(free_vec);

   wire cmd_fail = is_addr && (!ch_ok || (need_eng && !avail) ||
                   (is_start && !params_ok));
   // op none answers not-ok and still raises the fail event
   wire cmd_ok   = (cmd_op != pulse_pkg::OP_NONE) && !cmd_fail;
   wire reset_all = cmd_go && (cmd_op == pulse_pkg::OP_RESET_ALL);

   // status answer: true only while an engine owns that output, running or forced
   wire running  = ch_ok && hit;

   pulse_pkg::pulse_cfg_t cfg;
   assign cfg = '{
      low_time:  low_time[14:0],
      high_time: high_time[14:0],
      pulse_num: pulse_num,
      counted:   (cmd_op == pulse_pkg::OP_COUNTED)
   };

   ms_tick_gen #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .tick    (tick)
   );

   generate
      for (e = 0; e < NE; e++) begin : g_eng
         wire mine = cmd_go && cmd_ok && (sel == 3'(e));

         pulse_channel u_chan (
            .sys_clk    (sys_clk),
            .rstn       (rstn),
            .tick       (tick),
            .start      (mine && is_start),
            .force_high (mine && (cmd_op == pulse_pkg::OP_FORCE_HIGH)),
            .force_low  (mine && (cmd_op == pulse_pkg::OP_FORCE_LOW)),
            .stop       (reset_all || (mine && hit && (cmd_op == pulse_pkg::OP_DISABLE))),
            .cfg        (cfg),
            .busy       (eng_busy[e]),
            .level      (eng_level[e]),
            .done       (eng_done[e])
         );

         // owner index outlives release; busy gates every use
         always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn)
               target[e] <= 8'h00;
            else if (mine && need_eng)
               target[e] <= out_idx;
         end
      end
   endgenerate

   // outputs: owning engine's level, else the scan value; registered
   generate
      genvar o;
      for (o = 0; o < pulse_pkg::NUM_OUTPUTS; o++) begin : g_out
         logic [NE-1:0] own;
         for (genvar k = 0; k < NE; k++) begin : g_own
            assign own[k] = eng_busy[k] && (target[k] == 8'(o));
         end
         // registered so a pin never glitches as ownership moves
         wire next_out = (|own) ? |(own & eng_level) : scan_out[o];

         always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn)
               channel_out[o] <= 1'b0;
            else
               channel_out[o] <= next_out;
         end
      end
   endgenerate

   // register writes
   wire wr_low  = wr_en && (addr_q == pulse_pkg::OFF_LOW_TIME);
   wire wr_high = wr_en && (addr_q == pulse_pkg::OFF_HIGH_TIME);
   wire wr_num  = wr_en && (addr_q == pulse_pkg::OFF_PULSE_NUM);
   wire wr_cfg  = wr_en && (addr_q == pulse_pkg::OFF_CONFIG);
   wire wr_clr  = wr_en && (addr_q == pulse_pkg::OFF_IRQ_STATUS);
   wire wr_mask = wr_en && (addr_q == pulse_pkg::OFF_IRQ_MASK);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         low_time <= pulse_pkg::LOW_TIME_RST;
      else if (wr_low)
         low_time <= hwdata[15:0];
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         high_time <= pulse_pkg::HIGH_TIME_RST;
      else if (wr_high)
         high_time <= hwdata[15:0];
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         pulse_num <= pulse_pkg::PULSE_NUM_RST;
      else if (wr_num)
         pulse_num <= hwdata;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         coarse <= 1'b0;
      else if (wr_cfg)
         coarse <= hwdata[0];
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         irq_mask <= pulse_pkg::IRQ_RST;
      else if (wr_mask)
         irq_mask <= hwdata[1:0];
   end

   // result holds the last answer until the next command
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         result <= pulse_pkg::RESULT_RST;
      else if (cmd_go)
         result <= {running && (cmd_op == pulse_pkg::OP_STATUS), cmd_ok};
   end

   // sticky events; a new event beats a clear in the same cycle
   wire [1:0] irq_set = {|eng_done, cmd_go && !cmd_ok};
   wire [1:0] irq_clr = wr_clr ? hwdata[1:0] : 2'h0;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         irq_status <= pulse_pkg::IRQ_RST;
      else
         irq_status <= (irq_status & ~irq_clr) | irq_set;
   end

   // level output: software clears the cause, not the line
   assign irq = |(irq_status & irq_mask);

   // read mux over registered state; unmapped offsets read zero
   logic [31:0] rd_word;
   always_comb begin
      case (addr_q)
         pulse_pkg::OFF_LOW_TIME:   rd_word = {16'h0000, low_time};
         pulse_pkg::OFF_HIGH_TIME:  rd_word = {16'h0000, high_time};
         pulse_pkg::OFF_PULSE_NUM:  rd_word = pulse_num;
         pulse_pkg::OFF_RESULT:     rd_word = {30'h0000_0000, result};
         pulse_pkg::OFF_CONFIG:     rd_word = {31'h0000_0000, coarse};
         pulse_pkg::OFF_IRQ_STATUS: rd_word = {30'h0000_0000, irq_status};
         pulse_pkg::OFF_IRQ_MASK:   rd_word = {30'h0000_0000, irq_mask};
         pulse_pkg::OFF_ENG_STATE:  rd_word = {24'h00_0000, eng_busy};
         default:                   rd_word = 32'h0000_0000;
      endcase
   end

   // zero outside a read data phase keeps the read bus quiet
   assign hrdata = rd_pend ? rd_word : 32'h0000_0000;

   // hsize is fixed to words here
   wire unused_ok = &{1'b0, hsize, haddr[31:8]};
endmodule // multichannel_pulse_output
`default_nettype wire

// *** hdl/pulse_pkg.sv ***
// constants, command codes and carrier types of the multichannel pulse output block
package pulse_pkg;

   // timing
   localparam int unsigned CLK_HZ        = 100_000_000;
   localparam int unsigned TICK_TIME_MS  = 1;
   localparam int unsigned TICK_CYCLES   = CLK_HZ / 1000 * TICK_TIME_MS;

   // geometry
   localparam int unsigned NUM_ENGINES   = 8;
   localparam int unsigned NUM_SLOTS     = 8;
   localparam int unsigned CH_PER_SLOT   = 32;
   localparam int unsigned NUM_OUTPUTS   = NUM_SLOTS * CH_PER_SLOT;

   // accepted phase lengths, in ticks
   localparam logic [15:0] FINE_MIN      = 16'h0001;
   localparam logic [15:0] FINE_MAX      = 16'h7fff;
   localparam logic [15:0] COARSE_MIN    = 16'h0002;
   localparam logic [15:0] COARSE_MAX    = 16'h7ffe;

   // register byte offsets
   localparam logic [7:0] OFF_CMD        = 8'h00;
   localparam logic [7:0] OFF_LOW_TIME   = 8'h04;
   localparam logic [7:0] OFF_HIGH_TIME  = 8'h08;
   localparam logic [7:0] OFF_PULSE_NUM  = 8'h0c;
   localparam logic [7:0] OFF_RESULT     = 8'h10;
   localparam logic [7:0] OFF_CONFIG     = 8'h14;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK   = 8'h1c;
   localparam logic [7:0] OFF_ENG_STATE  = 8'h20;

   // command word fields
   localparam int unsigned CMD_OP_LSB    = 0;
   localparam int unsigned CMD_SLOT_LSB  = 8;
   localparam int unsigned CMD_CH_LSB    = 16;

   // command codes
   localparam logic [2:0] OP_NONE        = 3'h0;
   localparam logic [2:0] OP_CONTINUOUS  = 3'h1;
   localparam logic [2:0] OP_COUNTED     = 3'h2;
   localparam logic [2:0] OP_FORCE_HIGH  = 3'h3;
   localparam logic [2:0] OP_FORCE_LOW   = 3'h4;
   localparam logic [2:0] OP_DISABLE     = 3'h5;
   localparam logic [2:0] OP_STATUS      = 3'h6;
   localparam logic [2:0] OP_RESET_ALL   = 3'h7;

   // result and interrupt bit positions
   localparam int unsigned RES_OK        = 0;
   localparam int unsigned RES_RUNNING   = 1;
   localparam int unsigned IRQ_FAIL      = 0;
   localparam int unsigned IRQ_DONE      = 1;

   // reset values
   localparam logic [15:0] LOW_TIME_RST  = 16'h0001;
   localparam logic [15:0] HIGH_TIME_RST = 16'h0001;
   localparam logic [31:0] PULSE_NUM_RST = 32'hffff_ffff;
   localparam logic [1:0]  RESULT_RST    = 2'h0;
   localparam logic [1:0]  IRQ_RST       = 2'h0;

   typedef struct packed {
      logic [14:0]        low_time;
      logic [14:0]        high_time;
      logic signed [31:0] pulse_num;
      logic               counted;
   } pulse_cfg_t;

endpackage

// *** hdl/ms_tick_gen.sv ***
// shared millisecond tick strobe derived from the system clock
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen #(
   parameter int unsigned CYCLES = pulse_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rstn,
   // strobe
   output logic      tick
);
   localparam int unsigned W = $clog2(CYCLES + 1);

   logic [W-1:0] count;
   wire          wrap = (count == W'(CYCLES - 1));

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         count <= wrap ? '0 : count + W'(1);
         tick  <= wrap;
      end
   end
endmodule // ms_tick_gen
`default_nettype wire

// *** hdl/pulse_channel.sv ***
// one pulse engine: low/high waveform, counted runs and forced levels
`timescale 1ns/1ps
`default_nettype none
module pulse_channel (
   // clock and reset
   input  wire logic                 sys_clk,
   input  wire logic                 rstn,
   // controls
   input  wire logic                 tick,
   input  wire logic                 start,
   input  wire logic                 force_high,
   input  wire logic                 force_low,
   input  wire logic                 stop,
   input  wire pulse_pkg::pulse_cfg_t cfg,
   // state
   output logic                      busy,
   output logic                      level,
   output logic                      done
);
   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FORCE} eng_state_t;

   eng_state_t            state;
   logic                  phase;
   logic [14:0]           tcnt;
   logic [31:0]           remain;
   logic                  endless;
   pulse_pkg::pulse_cfg_t cfg_q;

   wire [14:0] next_tcnt  = tcnt + 15'h0001;
   wire [14:0] phase_len  = phase ? cfg_q.high_time : cfg_q.low_time;
   wire        phase_end  = (state == ST_RUN) && tick && (next_tcnt >= phase_len);
   wire        last_pulse = phase_end && phase && !endless && (remain == 32'h0000_0001);

   assign busy = (state != ST_IDLE);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         level <= 1'b0;
      end else if (stop || last_pulse) begin
         state <= ST_IDLE;
         level <= 1'b0;
      end else if (start) begin
         state <= ST_RUN;
         level <= 1'b0;
      end else if (force_high || force_low) begin
         state <= ST_FORCE;
         level <= force_high;
      end else if (phase_end) begin
         level <= !phase;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         phase   <= 1'b0;
         tcnt    <= 15'h0000;
         remain  <= 32'h0000_0000;
         endless <= 1'b0;
         cfg_q   <= '0;
      end else if (start) begin
         phase   <= 1'b0;
         tcnt    <= 15'h0000;
         remain  <= cfg.pulse_num;
         endless <= !cfg.counted || cfg.pulse_num[31];
         cfg_q   <= cfg;
      end else if (phase_end) begin
         phase  <= !phase;
         tcnt   <= 15'h0000;
         remain <= phase ? remain - 32'h0000_0001 : remain;
      end else if (state == ST_RUN && tick) begin
         tcnt <= next_tcnt;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn)
         done <= 1'b0;
      else
         done <= last_pulse && !stop;
   end
endmodule // pulse_channel
`default_nettype wire

// *** sim/pulse_output_monitor.sv ***
// port checker for the multichannel pulse output block
`timescale 1ns/1ps
`default_nettype none
module pulse_output_monitor #(
   parameter int unsigned TICK_CYCLES = pulse_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   // ahb-lite slave
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic [31:0]  hwdata,
   input  wire logic         hready,
   input  wire logic         hreadyout,
   input  wire logic         hresp,
   input  wire logic [31:0]  hrdata,
   // output boards
   input  wire logic [7:0]   board_present,
   input  wire logic [255:0] scan_out,
   input  wire logic [255:0] channel_out,
   // interrupt
   input  wire logic         irq
);
   logic       wr_cmd;
   logic       rd_ph;
   logic       out0;
   logic [2:0] op;

   assign op   = hwdata[2:0];
   assign out0 = wr_cmd && (hwdata[31:3] == 29'h0000_2000);

   // data phase markers rebuilt from the address phase
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         wr_cmd <= 1'b0;
         rd_ph  <= 1'b0;
      end else if (hready) begin
         wr_cmd <= hsel && htrans[1] && hwrite && (haddr[7:0] == pulse_pkg::OFF_CMD);
         rd_ph  <= hsel && htrans[1] && !hwrite;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   property p_bus_okay;
      hresp == 1'b0 && hreadyout == 1'b1;
   endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("bus response not okay");

   property p_rdata_idle;
      !rd_ph |-> hrdata == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside data phase");

   property p_reset_quiet;
      $rose(rstn) |-> channel_out == {256{1'b0}} && !irq;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet in reset");

   property p_absent_slot;
      $past(rstn) && !$past(board_present[7]) && !board_present[7]
         |-> channel_out[255:224] == $past(scan_out[255:224]);
   endproperty
   a_absent_slot: assert property (p_absent_slot) else $error("empty slot driven");

   property p_force_high;
      out0 && op == pulse_pkg::OP_FORCE_HIGH |-> ##2 channel_out[0];
   endproperty
   a_force_high: assert property (p_force_high) else $error("force high not seen");

   property p_force_low;
      out0 && op == pulse_pkg::OP_FORCE_LOW |-> ##2 !channel_out[0];
   endproperty
   a_force_low: assert property (p_force_low) else $error("force low not seen");

   property p_disable;
      out0 && op == pulse_pkg::OP_DISABLE |-> ##2 channel_out[0] == $past(scan_out[0]);
   endproperty
   a_disable: assert property (p_disable) else $error("disabled output not on scan");

   property p_reset_all;
      wr_cmd && op == pulse_pkg::OP_RESET_ALL |-> ##2 channel_out == $past(scan_out);
   endproperty
   a_reset_all: assert property (p_reset_all) else $error("reset all left outputs");

   c_force: cover property (out0 && op == pulse_pkg::OP_FORCE_HIGH);
   c_counted: cover property (wr_cmd && op == pulse_pkg::OP_COUNTED);
   c_read: cover property (rd_ph && hrdata != 32'h0);
endmodule // pulse_output_monitor

bind multichannel_pulse_output pulse_output_monitor #(.TICK_CYCLES(TICK_CYCLES))
   pulse_output_monitor_i (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .board_present(board_present),
   .scan_out(scan_out), .channel_out(channel_out), .irq(irq));
`default_nettype wire

// *** sim/output_board_model.sv ***
// far side model: fitted output boards and the ordinary scan values
`timescale 1ns/1ps
`default_nettype none
module output_board_model #(
   parameter logic [7:0] FITTED = 8'h7f
) (
   // scan pattern select
   input  wire logic     scan_flip,
   // board side
   output logic [7:0]    board_present,
   output logic [255:0]  scan_out
);
   // slot 7 stays empty so missing outputs can be addressed
   assign board_present = FITTED;
   assign scan_out      = {32{8'ha5}} ^ {256{scan_flip}};
endmodule // output_board_model
`default_nettype wire

// *** sim/multichannel_pulse_output_tb_top.sv ***
// self-checking bench for the multichannel pulse output block
`timescale 1ns/1ps
`default_nettype none
module multichannel_pulse_output_tb_top;
   localparam int unsigned TICKS = 10;
   logic         sys_clk;
   logic         rstn;
   logic         hsel;
   logic [31:0]  haddr;
   logic [1:0]   htrans;
   logic         hwrite;
   logic [2:0]   hsize;
   logic [31:0]  hwdata;
   logic         hready;
   logic         hreadyout;
   logic         hresp;
   logic [31:0]  hrdata;
   logic [7:0]   board_present;
   logic [255:0] scan_out;
   logic [255:0] channel_out;
   logic         irq;
   logic         scan_flip;
   logic [31:0]  rd_q;
   logic [31:0]  r;
   int           err_total;
   int           cmp_count;
   int           n;
   logic [55:0]  tbl [13];

   assign hready = hreadyout;

   multichannel_pulse_output #(.TICK_CYCLES(TICKS)) multichannel_pulse_output_i (
      .sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .board_present(board_present), .scan_out(scan_out), .channel_out(channel_out),
      .irq(irq));
   output_board_model output_board_model_i (
      .scan_flip(scan_flip), .board_present(board_present), .scan_out(scan_out));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) rd_q <= hrdata;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one single transfer; read data is the value held at the closing edge
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      haddr <= {24'h0, a};
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      #1 r = rd_q;
   endtask

   task automatic cmd(input logic [2:0] op, input logic [2:0] sl, input logic [5:0] ch,
                      input logic ok);
      bus(pulse_pkg::OFF_CMD, 1'b1, {10'h0, ch, 5'h0, sl, 5'h0, op});
      bus(pulse_pkg::OFF_RESULT, 1'b0, 32'h0);
      check({31'h0, r[0]}, {31'h0, ok});
   endtask

   task automatic wait_lvl(input int idx, input logic v);
      n = 0;
      while (channel_out[idx] !== v && n < 2000) begin
         @(posedge sys_clk);
         #1 n++;
      end
   endtask

   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge sys_clk);
      err_total++;
      finish_test();
   end

   initial begin
      rstn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      scan_flip = 1'b1;
      err_total = 0;
      cmp_count = 0;
      tbl = '{56'h0_1_7fff_7fff_0_03_1, 56'h0_1_0000_0005_0_03_0, 56'h0_1_0005_8000_0_03_0,
              56'h1_1_0002_7ffe_0_03_1, 56'h1_1_0003_0002_0_03_0, 56'h1_1_0002_7fff_0_03_0,
              56'h0_2_0002_0002_0_03_0, 56'h0_3_0001_0001_0_00_0, 56'h0_4_0001_0001_0_21_0,
              56'h0_3_0001_0001_7_01_0, 56'h0_0_0001_0001_0_01_0, 56'h0_6_0001_0001_7_01_0,
              56'h0_5_0001_0001_0_00_0};
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      bus(pulse_pkg::OFF_PULSE_NUM, 1'b0, 32'h0);
      check(r, 32'hffff_ffff);
      bus(pulse_pkg::OFF_ENG_STATE, 1'b0, 32'h0);
      check(r, 32'h0);
      bus(8'h3c, 1'b0, 32'h0);
      check(r, 32'h0);
      check(channel_out[31:0], 32'h5a5a_5a5a);
      // forced levels, status and hand-back to scan on output 0
      cmd(pulse_pkg::OP_FORCE_HIGH, 3'h0, 6'h01, 1'b1);
      check({31'h0, channel_out[0]}, 32'h1);
      scan_flip <= 1'b0;
      cmd(pulse_pkg::OP_FORCE_LOW, 3'h0, 6'h01, 1'b1);
      check({31'h0, channel_out[0]}, 32'h0);
      cmd(pulse_pkg::OP_STATUS, 3'h0, 6'h01, 1'b1);
      check({31'h0, r[1]}, 32'h1);
      cmd(pulse_pkg::OP_DISABLE, 3'h0, 6'h01, 1'b1);
      check({31'h0, channel_out[0]}, 32'h1);
      cmd(pulse_pkg::OP_STATUS, 3'h0, 6'h01, 1'b1);
      check({31'h0, r[1]}, 32'h0);
      cmd(pulse_pkg::OP_CONTINUOUS, 3'h0, 6'h01, 1'b1);
      cmd(pulse_pkg::OP_STATUS, 3'h0, 6'h01, 1'b1);
      check({31'h0, r[1]}, 32'h1);
      cmd(pulse_pkg::OP_DISABLE, 3'h0, 6'h01, 1'b1);
      // parameter limits, missing outputs, fail interrupt raised and cleared
      bus(pulse_pkg::OFF_PULSE_NUM, 1'b1, 32'h0);
      bus(pulse_pkg::OFF_IRQ_MASK, 1'b1, 32'h1);
      foreach (tbl[i]) begin
         bus(pulse_pkg::OFF_CONFIG, 1'b1, {28'h0, tbl[i][55:52]});
         bus(pulse_pkg::OFF_LOW_TIME, 1'b1, {16'h0, tbl[i][47:32]});
         bus(pulse_pkg::OFF_HIGH_TIME, 1'b1, {16'h0, tbl[i][31:16]});
         cmd(tbl[i][50:48], tbl[i][14:12], tbl[i][9:4], tbl[i][0]);
         check({31'h0, irq}, {31'h0, !tbl[i][0]});
         bus(pulse_pkg::OFF_IRQ_STATUS, 1'b1, 32'h3);
         if (tbl[i][0]) cmd(pulse_pkg::OP_DISABLE, tbl[i][14:12], tbl[i][9:4], 1'b1);
      end
      // counted run of two pulses on output 1, done interrupt masked first
      scan_flip <= 1'b1;
      bus(pulse_pkg::OFF_CONFIG, 1'b1, 32'h0);
      bus(pulse_pkg::OFF_LOW_TIME, 1'b1, 32'h2);
      bus(pulse_pkg::OFF_HIGH_TIME, 1'b1, 32'h3);
      bus(pulse_pkg::OFF_PULSE_NUM, 1'b1, 32'h2);
      cmd(pulse_pkg::OP_COUNTED, 3'h0, 6'h02, 1'b1);
      check({31'h0, channel_out[1]}, 32'h0);
      wait_lvl(1, 1'b1);
      wait_lvl(1, 1'b0);
      check(n, 3 * TICKS);
      wait_lvl(1, 1'b1);
      check(n, 2 * TICKS);
      repeat (3 * TICKS + 4) @(posedge sys_clk);
      #1;
      check({31'h0, channel_out[1]}, 32'h1);
      cmd(pulse_pkg::OP_STATUS, 3'h0, 6'h02, 1'b1);
      check({31'h0, r[1]}, 32'h0);
      check({31'h0, irq}, 32'h0);
      bus(pulse_pkg::OFF_IRQ_MASK, 1'b1, 32'h2);
      check({31'h0, irq}, 32'h1);
      bus(pulse_pkg::OFF_IRQ_STATUS, 1'b1, 32'h2);
      check({31'h0, irq}, 32'h0);
      // negative target keeps running until disabled
      bus(pulse_pkg::OFF_PULSE_NUM, 1'b1, 32'hffff_ffff);
      cmd(pulse_pkg::OP_COUNTED, 3'h0, 6'h05, 1'b1);
      repeat (200) @(posedge sys_clk);
      cmd(pulse_pkg::OP_STATUS, 3'h0, 6'h05, 1'b1);
      check({31'h0, r[1]}, 32'h1);
      cmd(pulse_pkg::OP_DISABLE, 3'h0, 6'h05, 1'b1);
      // eight engines fill, a ninth output is refused, reset all frees them
      for (int c = 1; c <= 8; c++) cmd(pulse_pkg::OP_FORCE_HIGH, 3'h1, c[5:0], 1'b1);
      cmd(pulse_pkg::OP_FORCE_HIGH, 3'h1, 6'h09, 1'b0);
      bus(pulse_pkg::OFF_ENG_STATE, 1'b0, 32'h0);
      check(r, 32'hff);
      cmd(pulse_pkg::OP_RESET_ALL, 3'h0, 6'h01, 1'b1);
      bus(pulse_pkg::OFF_ENG_STATE, 1'b0, 32'h0);
      check(r, 32'h0);
      check(channel_out[63:32], 32'h5a5a_5a5a);
      finish_test();
   end
endmodule // multichannel_pulse_output_tb_top
`default_nettype wire
